// *** boex_pkg.sv ***
package boex_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_INSTR = 8'h00;
    localparam logic [7:0] OFF_ACCUM = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_PC = 8'h0c;
    localparam logic [7:0] OFF_FIDX = 8'h10;
    localparam logic [7:0] OFF_FDATA = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int INS_OP_LSB = 8;
    localparam int INS_D_BIT = 7;
    localparam int ST_EXTRA_BIT = 0;
    localparam int ST_NULL_BIT = 2;
    localparam int ST_GIE_BIT = 7;
    localparam int INS_BUSY_BIT = 31;

    // ------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_IDLE = 4'h0,
        OP_OR = 4'h1,
        OP_STORE = 4'h2,
        OP_COPY = 4'h3,
        OP_RETI = 4'h4,
        OP_RL = 4'h5,
        OP_RR = 4'h6,
        OP_RETK = 4'h7
    } boex_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_FLUSH = 2'h2
    } boex_state_e;

endpackage : boex_pkg

// *** boex_core.sv ***
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
// Functional notes
// - OR of accumulator and file register goes to accumulator or file, null flag updated.
// - Store copies the accumulator into the file register and touches no flag.
// - Copy moves a file register to accumulator or back to itself and updates the null flag.
// - Copy back to its source leaves it intact while still updating the null flag.
// - Return from interrupt loads the counter from the stack head and sets irq enable.
// - Rotate left moves the extra bit into bit 0 and old bit 7 into the extra bit.
// - Rotate right moves the extra bit into bit 7 and old bit 0 into the extra bit.
// - Return with constant loads the accumulator with the immediate and the counter from the stack head.
// - Return with constant takes two instruction cycles.
// - Every return pops the hardware stack.
module boex_core
    import boex_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int PC_W = 13
)(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PC_W-1:0] stack_head,
    output logic stack_pop,
    output logic [PC_W-1:0] prog_counter
);

    if (ADDR_W < 8 || PC_W < 1 || PC_W > 31)
    begin : g_bad_param
        $error("boex_core: ADDR_W must be >= 8 and PC_W within 1..31");
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------
    // AXI4-Lite write channel
    // ------------------------------------------------------------
    logic awready_q, wready_q, bvalid_q, aw_full_q, w_full_q;
    logic [1:0] bresp_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_full_d, w_full_d, wr_go, wr_ok;
    boex_state_e st_q;

    assign wr_go = aw_full_q && w_full_q && !bvalid_q && st_q == ST_IDLE;
    assign aw_full_d = wr_go ? 1'b0 : (aw_full_q || (s_axi_awvalid && awready_q));
    assign w_full_d = wr_go ? 1'b0 : (w_full_q || (s_axi_wvalid && wready_q));
    assign wr_ok = waddr_q inside {OFF_INSTR, OFF_ACCUM, OFF_STATUS, OFF_PC, OFF_FIDX,
                                   OFF_FDATA};

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= !aw_full_d;
            wready_q <= !w_full_d;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && awready_q)
            begin
                waddr_q <= s_axi_awaddr[7:0];
            end
            if (s_axi_wvalid && wready_q)
            begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            bvalid_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Execution datapath
    // ------------------------------------------------------------
    logic [7:0] file_q [128];
    logic [7:0] acc_q, res_d, fsel, kval;
    logic [6:0] fptr_q, fidx;
    logic [11:0] instr_q;
    logic [PC_W-1:0] pc_q;
    logic null_q, extra_q, gie_q, pop_q, exec, dbit, is_ret, to_acc, to_file;
    boex_op_e op;
    logic [31:0] ins_m, acc_m, pc_m;

    assign op = boex_op_e'(instr_q[INS_OP_LSB +: 4]);
    // Byte-merged register images for software writes
    assign ins_m = merge({20'h00000, instr_q}, wdata_q, wstrb_q);
    assign acc_m = merge({24'h000000, acc_q}, wdata_q, wstrb_q);
    assign pc_m = merge(32'(pc_q), wdata_q, wstrb_q);
    assign dbit = instr_q[INS_D_BIT];
    assign fidx = instr_q[6:0];
    assign kval = instr_q[7:0];
    assign fsel = file_q[fidx];
    assign exec = st_q == ST_EXEC;
    assign is_ret = op == OP_RETI || op == OP_RETK;
    assign to_acc = exec && !dbit && op inside {OP_OR, OP_COPY, OP_RL, OP_RR};
    assign to_file = exec && dbit && op inside {OP_OR, OP_COPY, OP_RL, OP_RR};

    always_comb
    begin
        case (op)
            OP_OR: res_d = acc_q | fsel;
            OP_RL: res_d = {fsel[6:0], extra_q};
            OP_RR: res_d = {extra_q, fsel[7:1]};
            default: res_d = fsel;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            instr_q <= 12'h000;
        end
        else if (wr_go && waddr_q == OFF_INSTR)
        begin
            instr_q <= ins_m[11:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= ST_IDLE;
        end
        else
        begin
            case (st_q)
                ST_IDLE: st_q <= (wr_go && waddr_q == OFF_INSTR) ? ST_EXEC : ST_IDLE;
                ST_EXEC: st_q <= is_ret ? ST_FLUSH : ST_IDLE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            acc_q <= ACCUM_RST;
        end
        else if (to_acc)
        begin
            acc_q <= res_d;
        end
        else if (exec && op == OP_RETK)
        begin
            acc_q <= kval;
        end
        else if (wr_go && waddr_q == OFF_ACCUM)
        begin
            acc_q <= acc_m[7:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (exec && op == OP_STORE)
        begin
            file_q[fidx] <= acc_q;
        end
        else if (to_file)
        begin
            file_q[fidx] <= res_d;
        end
        else if (wr_go && waddr_q == OFF_FDATA && wstrb_q[0])
        begin
            file_q[fptr_q] <= wdata_q[7:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fptr_q <= 7'h00;
        end
        else if (wr_go && waddr_q == OFF_FIDX && wstrb_q[0])
        begin
            fptr_q <= wdata_q[6:0];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            null_q <= 1'b0;
            extra_q <= 1'b0;
            gie_q <= 1'b0;
        end
        else if (exec)
        begin
            if (op == OP_OR || op == OP_COPY)
            begin
                null_q <= res_d == 8'h00;
            end
            if (op == OP_RL)
            begin
                extra_q <= fsel[7];
            end
            if (op == OP_RR)
            begin
                extra_q <= fsel[0];
            end
            if (op == OP_RETI)
            begin
                gie_q <= 1'b1;
            end
        end
        else if (wr_go && waddr_q == OFF_STATUS && wstrb_q[0])
        begin
            null_q <= wdata_q[ST_NULL_BIT];
            extra_q <= wdata_q[ST_EXTRA_BIT];
            gie_q <= wdata_q[ST_GIE_BIT];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pc_q <= '0;
            pop_q <= 1'b0;
        end
        else
        begin
            pop_q <= exec && is_ret;
            if (exec)
            begin
                pc_q <= is_ret ? stack_head : pc_q + PC_W'(1);
            end
            else if (wr_go && waddr_q == OFF_PC)
            begin
                pc_q <= pc_m[PC_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    logic arready_q, rvalid_q, rvalid_d, rd_ok;
    logic [31:0] rdata_q, rd_data;
    logic [1:0] rresp_q;

    assign rvalid_d = (s_axi_arvalid && arready_q) || (rvalid_q && !s_axi_rready);

    always_comb
    begin
        rd_ok = 1'b1;
        rd_data = 32'h0000_0000;
        case (s_axi_araddr[7:0])
            OFF_INSTR: rd_data = {st_q != ST_IDLE, 19'h00000, instr_q};
            OFF_ACCUM: rd_data[7:0] = acc_q;
            OFF_STATUS:
            begin
                rd_data[ST_NULL_BIT] = null_q;
                rd_data[ST_EXTRA_BIT] = extra_q;
                rd_data[ST_GIE_BIT] = gie_q;
            end
            OFF_PC: rd_data[PC_W-1:0] = pc_q;
            OFF_FIDX: rd_data[6:0] = fptr_q;
            OFF_FDATA: rd_data[7:0] = file_q[fptr_q];
            default: rd_ok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            arready_q <= !rvalid_d;
            rvalid_q <= rvalid_d;
            if (s_axi_arvalid && arready_q)
            begin
                rdata_q <= rd_data;
                rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign stack_pop = pop_q;
    assign prog_counter = pc_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_OR: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_OR && !dbit |=> acc_q == $past(acc_q | fsel)
        && null_q == (acc_q == 8'h00)) else $error("or result wrong");
    AST_STORE: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_STORE |=> file_q[$past(fidx)] == $past(acc_q)
        && $stable(null_q) && $stable(extra_q)) else $error("store wrong");
    AST_COPY: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_COPY && !dbit |=> acc_q == $past(fsel)) else $error("copy wrong");
    AST_TEST: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_COPY && dbit |=> file_q[$past(fidx)] == $past(fsel)
        && null_q == ($past(fsel) == 8'h00)) else $error("copy test wrong");
    AST_RETI: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_RETI |=> pc_q == $past(stack_head) && gie_q)
        else $error("irq return wrong");
    AST_RL: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_RL && dbit |=> extra_q == $past(fsel[7])
        && file_q[$past(fidx)] == {$past(fsel[6:0]), $past(extra_q)}) else $error("rl wrong");
    AST_RR: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_RR && !dbit |=> extra_q == $past(fsel[0])
        && acc_q == {$past(extra_q), $past(fsel[7:1])}) else $error("rr wrong");
    AST_RETK: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_RETK |=> acc_q == $past(kval) && pc_q == $past(stack_head))
        else $error("constant return wrong");
    AST_TWO: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && is_ret |=> st_q == ST_FLUSH ##1 st_q == ST_IDLE) else $error("not two cycles");
    AST_POP: assert property (@(posedge aclk) disable iff (!aresetn)
        pop_q == $past(exec && is_ret)) else $error("pop mismatch");
    AST_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_IDLE |=> pc_q == $past(pc_q) + PC_W'(1) && $stable(acc_q)
        && st_q == ST_IDLE) else $error("idle wrong");
    AST_RETI2: assert property (@(posedge aclk) disable iff (!aresetn)
        exec && op == OP_RETI |=> st_q == ST_FLUSH && !exec) else $error("irq return short");

endmodule : boex_core

// *** boex_tb.sv ***
`timescale 1ns/10ps
module testbench
    import boex_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    typedef struct {
        logic [11:0] ins;
        logic [7:0] acc, fil, st, eacc, efil, est;
        logic ret;
    } boex_row_s;
    logic aclk, aresetn;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, stack_pop;
    logic [1:0] bresp, rresp;
    logic [12:0] prog_counter, sh, pc0;
    logic [12:0] stack_head = 13'h0a5c;
    logic [31:0] d;
    logic [1:0] r;
    int error_cnt, total_checks, np;
    int pops = 0;
    boex_row_s rows[14];

    boex_core uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .stack_head(stack_head),
        .stack_pop(stack_pop), .prog_counter(prog_counter)
    );

    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Pop pulses are counted per high cycle; the stack moves to its next entry
    always @(posedge aclk)
    begin
        if (stack_pop === 1'b1)
        begin
            pops <= pops + 1;
            stack_head <= stack_head + 13'h0101;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge aclk);
            if (aw && awready === 1'b1)
            begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1)
            begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge aclk);
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wait_idle();
        do axi_rd(OFF_INSTR, d, r); while (d[INS_BUSY_BIT] !== 1'b0);
    endtask : wait_idle

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    initial
    begin
        #200000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        test_done();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        error_cnt = 0;
        total_checks = 0;
        rows = '{
            '{12'h105, 8'h0f, 8'h30, 8'h00, 8'h3f, 8'h30, 8'h00, 1'b0},
            '{12'h1ff, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h05, 1'b0},
            '{12'h200, 8'ha5, 8'h11, 8'h05, 8'ha5, 8'ha5, 8'h05, 1'b0},
            '{12'h309, 8'h00, 8'h80, 8'h04, 8'h80, 8'h80, 8'h00, 1'b0},
            '{12'h389, 8'h12, 8'h00, 8'h00, 8'h12, 8'h00, 8'h04, 1'b0},
            '{12'h503, 8'h55, 8'h41, 8'h05, 8'h83, 8'h41, 8'h04, 1'b0},
            '{12'h583, 8'h55, 8'h80, 8'h00, 8'h55, 8'h00, 8'h01, 1'b0},
            '{12'h604, 8'h55, 8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 1'b0},
            '{12'h684, 8'h55, 8'h02, 8'h01, 8'h55, 8'h81, 8'h00, 1'b0},
            '{12'h000, 8'h66, 8'h5a, 8'h85, 8'h66, 8'h5a, 8'h85, 1'b0},
            '{12'hf10, 8'h66, 8'h5a, 8'h80, 8'h66, 8'h5a, 8'h80, 1'b0},
            '{12'h7ff, 8'h00, 8'h3c, 8'h05, 8'hff, 8'h3c, 8'h05, 1'b1},
            '{12'h700, 8'hff, 8'h3c, 8'h00, 8'h00, 8'h3c, 8'h00, 1'b1},
            '{12'h400, 8'h77, 8'h3c, 8'h05, 8'h77, 8'h3c, 8'h85, 1'b1}
        };
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        foreach (rows[i])
        begin
            axi_wr(OFF_ACCUM, {24'h0, rows[i].acc}, r);
            axi_wr(OFF_STATUS, {24'h0, rows[i].st}, r);
            axi_wr(OFF_FIDX, {25'h0, rows[i].ins[6:0]}, r);
            axi_wr(OFF_FDATA, {24'h0, rows[i].fil}, r);
            sh = stack_head;
            pc0 = prog_counter;
            np = pops;
            axi_wr(OFF_INSTR, {20'h0, rows[i].ins}, r);
            chk(r, RESP_OKAY);
            wait_idle();
            axi_rd(OFF_ACCUM, d, r);
            chk(r, RESP_OKAY);
            chk(d[7:0], rows[i].eacc);
            axi_rd(OFF_FDATA, d, r);
            chk(d[7:0], rows[i].efil);
            axi_rd(OFF_STATUS, d, r);
            chk(d[7:0] & 8'h85, rows[i].est);
            axi_rd(OFF_PC, d, r);
            chk(d[12:0], rows[i].ret ? sh : pc0 + 13'h1);
            chk(prog_counter, rows[i].ret ? sh : pc0 + 13'h1);
            chk(pops - np, {31'h0, rows[i].ret});
        end
        $display("Test table done");

        // Two returns issued back to back, the second on the popped head
        sh = stack_head;
        np = pops;
        axi_wr(OFF_INSTR, 32'h0000_0742, r);
        axi_wr(OFF_INSTR, 32'h0000_0400, r);
        wait_idle();
        chk(prog_counter, sh + 13'h0101);
        chk(pops - np, 32'h2);
        axi_rd(OFF_ACCUM, d, r);
        chk(d[7:0], 8'h42);
        $display("Test back_to_back done");

        // Unmapped place
        axi_wr(8'h20, 32'h0000_00ff, r);
        chk(r, RESP_SLVERR);
        axi_rd(8'h20, d, r);
        chk(r, RESP_SLVERR);
        chk(d, 32'h0);
        axi_rd(OFF_ACCUM, d, r);
        chk(d[7:0], 8'h42);
        $display("Test unmapped done");

        // Program counter and file pointer registers
        axi_wr(OFF_PC, 32'h0000_1234, r);
        chk(r, RESP_OKAY);
        chk(prog_counter, 32'h0000_1234);
        axi_wr(OFF_INSTR, 32'h0000_0000, r);
        wait_idle();
        chk(prog_counter, 32'h0000_1235);
        axi_wr(OFF_FIDX, 32'h0000_07f5, r);
        axi_rd(OFF_FIDX, d, r);
        chk(r, RESP_OKAY);
        chk(d, 32'h0000_0075);
        $display("Test registers done");

        // Second reset in mid-run
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(prog_counter, 13'h0);
        axi_rd(OFF_ACCUM, d, r);
        chk(d[7:0], ACCUM_RST);
        axi_rd(OFF_STATUS, d, r);
        chk(d[7:0], 8'h00);
        $display("Test reset done");
        test_done();
    end
endmodule : testbench
